// file: logic/sbc_mode_regs.svh
// Constants of the operating-mode controller: frame fields, codes, times.
// Assumes a 100 MHz clock; included by bare name.
`ifndef SBC_MODE_REGS_SVH
`define SBC_MODE_REGS_SVH

// ****************
// Timing
// ****************
`define CLK_PERIOD_NS 10
`define RD_TIME_US 10
`define RD_CYCLES ((`RD_TIME_US * 1000) / `CLK_PERIOD_NS)
`define LW_TIME_MS 200
`define LW_CYCLES ((`LW_TIME_MS * 1000000) / `CLK_PERIOD_NS)

// ****************
// Frame layout
// ****************
`define FRAME_WRITE_BIT 7
`define FRAME_ADDR_MSB 6
`define FRAME_DATA_LSB 8

// ****************
// Addresses
// ****************
`define ADDR_MODE 7'h01
`define ADDR_WD 7'h02
`define ADDR_CFG 7'h03
`define ADDR_CAN 7'h04
`define ADDR_HS 7'h05
`define ADDR_WKEN 7'h06
`define ADDR_CLR 7'h07

// ****************
// Fields
// ****************
`define CFG_SECOND_REGULATOR_BIT 0
`define CFG_THIRD_REGULATOR_BIT 1
`define CFG_FO_TEST_BIT 2
`define CFG_CYC_WAKE_BIT 3
`define CFG_MEAS_BIT 4
`define CLR_SPI_ERR_BIT 6
`define CLR_UV_BIT 7
`define MEAS_MASK 4'hc

// ****************
// Codes
// ****************
`define REQ_NORMAL 2'h0
`define REQ_SLEEP 2'h1
`define REQ_STOP 2'h2
`define REQ_SOFT_RESET 2'h3
`define CAN_OFF 2'h0
`define CAN_WAKE 2'h1
`define CAN_RXONLY 2'h2
`define CAN_ACTIVE 2'h3
`define DEV_NONE 2'h0
`define DEV_RESTART 2'h1
`define DEV_SLEEP 2'h2

`endif

// file: logic/sbc_mode_pkg.sv
// Types and shared decoding of the operating-mode controller.
// Assumes the constants header is on the include path.
`include "sbc_mode_regs.svh"
package sbc_mode_pkg;

	typedef enum logic [2:0] {INIT, NORMAL, STOP, SLEEP, RESTART} mode_type;

	// Wake sources that may really wake; bit 3 is CAN
	function automatic logic [3:0] wake_usable(input logic [3:0] en, input logic meas);
		wake_usable = meas ? (en & `MEAS_MASK) : en;
	endfunction

endpackage

// file: logic/countdown_timer.sv
// Reloadable countdown; one-cycle expiry pulse.
// Assumes a single clock domain with the controller.
`timescale 1ns/1ps
module countdown_timer #(
	parameter int CYCLES = 1000
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Control
	input wire logic hold,
	// Status
	output logic expired_r
);

	localparam int W = $clog2(CYCLES + 1);

	logic [W-1:0] count_r;
	logic [W-1:0] count_nxt;
	logic expired_nxt;

	if (CYCLES < 1) begin : g_bad
		$error("countdown_timer needs at least one cycle");
	end

	always_comb begin
		count_nxt = count_r;
		expired_nxt = 1'b0;
		if (hold) begin
			count_nxt = W'(CYCLES);
		end else if (count_r != '0) begin
			count_nxt = count_r - W'(1);
			expired_nxt = (count_r == W'(1));
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			count_r <= W'(CYCLES);
			expired_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			expired_r <= expired_nxt;
		end
	end

endmodule

// file: logic/wake_capture.sv
// Wake pin and CAN wake capture with sticky flags.
// Assumes pins are asynchronous; control comes from the same clock.
`timescale 1ns/1ps
module wake_capture (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Pins
	input wire logic [2:0] wake_inputs,
	input wire logic can_wake,
	// Control
	input wire logic accept,
	input wire logic measure_select,
	input wire logic [3:0] source_enable,
	input wire logic [3:0] clear_mask,
	// Status
	output logic [3:0] flags_r,
	output logic event_r
);
	import sbc_mode_pkg::*;

	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic [3:0] last_r;
	logic [3:0] sync1_nxt;
	logic [3:0] sync2_nxt;
	logic [3:0] last_nxt;
	logic [3:0] flags_nxt;
	logic [3:0] hits;
	logic event_nxt;

	always_comb begin
		sync1_nxt = {can_wake, wake_inputs};
		sync2_nxt = sync1_r;
		last_nxt = sync2_r;
		// Nothing stored while not accepting
		hits = sync2_r & ~last_r & wake_usable(source_enable, measure_select) & {4{accept}};
		// Set wins over clear
		flags_nxt = (flags_r & ~clear_mask) | hits;
		event_nxt = |hits;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
			last_r <= 4'h0;
			flags_r <= 4'h0;
			event_r <= 1'b0;
		end else begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			last_r <= last_nxt;
			flags_r <= flags_nxt;
			event_r <= event_nxt;
		end
	end

endmodule

// file: logic/sbc_mode_control.sv
// Operating-mode controller: init, normal, stop, sleep and restart.
// Assumes a decoded 16-bit frame strobe on the same clock; supply
// comparators and wake pins are asynchronous.
`timescale 1ns/1ps
`include "sbc_mode_regs.svh"

module sbc_mode_control #(
	parameter int RD_CYCLES = `RD_CYCLES,
	parameter int LW_CYCLES = `LW_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Received frame
	input wire logic frame_valid,
	input wire logic [15:0] frame_data,
	// Supply comparators
	input wire logic main_below_reset,
	input wire logic battery_below_short,
	// Wake sources
	input wire logic [2:0] wake_inputs,
	input wire logic can_wake,
	// Mode and reset
	output sbc_mode_pkg::mode_type mode_r,
	output logic [1:0] mode_bits_r,
	output logic reset_output_r,
	output logic interrupt_r,
	// Supplies and drivers
	output logic main_regulator_r,
	output logic second_regulator_r,
	output logic third_regulator_r,
	output logic [1:0] can_mode_r,
	output logic [3:0] high_side_outputs_r,
	output logic fail_outputs_r,
	output logic cyclic_wake_r,
	output logic watchdog_on_r,
	output logic [7:0] watchdog_cfg_r,
	// Status
	output logic [2:0] wake_status_first_r,
	output logic wake_status_second_r,
	output logic [1:0] device_status_field_r,
	output logic main_supply_undervoltage_flag_r,
	output logic spi_error_flag_r,
	output logic watchdog_fail_r
);
	import sbc_mode_pkg::*;

	if (RD_CYCLES < 1 || LW_CYCLES < 1) begin : g_bad
		$error("sbc_mode_control timing counts must be positive");
	end

	// ****************
	// Frame decode
	// ****************
	logic wr;
	logic [6:0] addr;
	logic [7:0] data;
	logic [1:0] req;
	assign wr = frame_valid && frame_data[`FRAME_WRITE_BIT];
	assign addr = frame_data[`FRAME_ADDR_MSB:0];
	assign data = frame_data[15:`FRAME_DATA_LSB];
	assign req = data[1:0];

	// ****************
	// Pin synchronisers
	// ****************
	logic [1:0] pin1_r;
	logic [1:0] pin2_r;
	logic uv_s;
	logic batt_low_s;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pin1_r <= 2'h3;
			pin2_r <= 2'h3;
		end else begin
			pin1_r <= {battery_below_short, main_below_reset};
			pin2_r <= pin1_r;
		end
	end
	assign uv_s = pin2_r[0];
	assign batt_low_s = pin2_r[1];

	// ****************
	// State
	// ****************
	mode_type mode_nxt;
	logic [1:0] mode_bits_nxt;
	logic ro_nxt;
	logic irq_nxt;
	logic main_on_nxt;
	logic second_regulator_nxt;
	logic third_regulator_nxt;
	logic [1:0] can_nxt;
	logic [3:0] hs_nxt;
	logic fail_nxt;
	logic cyc_nxt;
	logic wd_on_nxt;
	logic [7:0] wd_cfg_nxt;
	logic [1:0] dev_nxt;
	logic uv_flag_nxt;
	logic spi_err_nxt;
	logic wd_fail_nxt;
	logic fo_test_r;
	logic fo_test_nxt;
	logic meas_r;
	logic meas_nxt;
	logic [3:0] wk_en_r;
	logic [3:0] wk_en_nxt;
	logic lw_active_r;
	logic lw_active_nxt;
	logic powerup_r;
	logic powerup_nxt;
	logic go_restart;
	logic sleep_wake;

	// ****************
	// Helpers
	// ****************
	logic rd_hold;
	logic rd_expired;
	logic lw_expired;
	logic [3:0] flags;
	logic wake_event;
	logic [3:0] clear_mask;
	logic any_flag;

	assign rd_hold = uv_s || !((mode_r == INIT && !reset_output_r) || mode_r == RESTART);
	assign clear_mask = (wr && addr == `ADDR_CLR && mode_r inside {INIT, NORMAL, STOP})
		? data[3:0] : 4'h0;
	assign any_flag = |flags;
	assign wake_status_first_r = flags[2:0];
	assign wake_status_second_r = flags[3];

	countdown_timer #(.CYCLES(RD_CYCLES)) rd_timer (
		.clock(clock),
		.rst_b(rst_b),
		.hold(rd_hold),
		.expired_r(rd_expired)
	);

	countdown_timer #(.CYCLES(LW_CYCLES)) lw_timer (
		.clock(clock),
		.rst_b(rst_b),
		.hold(!lw_active_r),
		.expired_r(lw_expired)
	);

	wake_capture wake (
		.clock(clock),
		.rst_b(rst_b),
		.wake_inputs(wake_inputs),
		.can_wake(can_wake),
		.accept(mode_r != INIT),
		.measure_select(meas_r),
		.source_enable(wk_en_r),
		.clear_mask(clear_mask),
		.flags_r(flags),
		.event_r(wake_event)
	);

	// ****************
	// Mode logic
	// ****************
	always_comb begin
		mode_nxt = mode_r;
		mode_bits_nxt = mode_bits_r;
		ro_nxt = reset_output_r;
		irq_nxt = 1'b0;
		main_on_nxt = main_regulator_r;
		second_regulator_nxt = second_regulator_r;
		third_regulator_nxt = third_regulator_r;
		can_nxt = can_mode_r;
		hs_nxt = high_side_outputs_r;
		fail_nxt = fail_outputs_r;
		cyc_nxt = cyclic_wake_r;
		wd_on_nxt = watchdog_on_r;
		wd_cfg_nxt = watchdog_cfg_r;
		dev_nxt = device_status_field_r;
		uv_flag_nxt = main_supply_undervoltage_flag_r;
		spi_err_nxt = spi_error_flag_r;
		wd_fail_nxt = watchdog_fail_r;
		fo_test_nxt = fo_test_r;
		meas_nxt = meas_r;
		wk_en_nxt = wk_en_r;
		lw_active_nxt = lw_active_r;
		powerup_nxt = powerup_r && uv_s;
		go_restart = 1'b0;
		sleep_wake = 1'b0;

		// Clears first so that a same-cycle set wins
		if (wr && addr == `ADDR_CLR && mode_r inside {INIT, NORMAL, STOP}) begin
			if (data[`CLR_UV_BIT]) uv_flag_nxt = 1'b0;
			if (data[`CLR_SPI_ERR_BIT]) spi_err_nxt = 1'b0;
		end
		if (uv_s && !(powerup_r && batt_low_s)) uv_flag_nxt = 1'b1;

		unique case (mode_r)
			INIT: begin
				if (rd_expired) begin
					ro_nxt = 1'b1;
					lw_active_nxt = 1'b1;
				end
				if (frame_valid) begin
					mode_nxt = NORMAL;
					mode_bits_nxt = `REQ_NORMAL;
					second_regulator_nxt = 1'b0;
					third_regulator_nxt = 1'b0;
					can_nxt = `CAN_OFF;
					hs_nxt = 4'h0;
					fo_test_nxt = 1'b0;
					fail_nxt = 1'b0;
				end
			end
			NORMAL: begin
				if (wake_event) irq_nxt = 1'b1;
				fail_nxt = fo_test_r;
				if (wr && addr == `ADDR_MODE) begin
					unique case (req)
						`REQ_NORMAL: mode_bits_nxt = `REQ_NORMAL;
						`REQ_STOP: begin
							mode_nxt = STOP;
							mode_bits_nxt = `REQ_STOP;
							irq_nxt = any_flag;
						end
						`REQ_SLEEP: begin
							if (wake_usable(wk_en_r, meas_r) == 4'h0) begin
								spi_err_nxt = 1'b1;
								go_restart = 1'b1;
							end else if (any_flag) begin
								go_restart = 1'b1;
								sleep_wake = 1'b1;
							end else begin
								mode_nxt = SLEEP;
								mode_bits_nxt = `REQ_SLEEP;
								main_on_nxt = 1'b0;
								wd_on_nxt = 1'b0;
								cyc_nxt = 1'b0;
								lw_active_nxt = 1'b0;
								if (can_mode_r != `CAN_OFF) can_nxt = `CAN_WAKE;
								dev_nxt = `DEV_SLEEP;
							end
						end
						`REQ_SOFT_RESET: go_restart = 1'b1;
					endcase
				end
			end
			STOP: begin
				if (wake_event) irq_nxt = 1'b1;
				if (wr) begin
					unique case (addr)
						`ADDR_MODE: begin
							if (req == `REQ_NORMAL) begin
								mode_nxt = NORMAL;
								mode_bits_nxt = `REQ_NORMAL;
							end else if (req == `REQ_SOFT_RESET) begin
								go_restart = 1'b1;
							end else begin
								spi_err_nxt = 1'b1;
								go_restart = (req == `REQ_SLEEP);
							end
						end
						`ADDR_WD: if (lw_active_r) lw_active_nxt = 1'b0;
						`ADDR_CLR: ;
						default: spi_err_nxt = 1'b1;
					endcase
				end
			end
			SLEEP: begin
				if (wake_event) begin
					go_restart = 1'b1;
					sleep_wake = 1'b1;
				end
			end
			RESTART: begin
				if (rd_expired) begin
					mode_nxt = NORMAL;
					ro_nxt = 1'b1;
					lw_active_nxt = 1'b1;
					second_regulator_nxt = 1'b0;
					hs_nxt = 4'h0;
				end
			end
		endcase

		// Configuration, frozen outside init and normal
		if (wr && mode_r inside {INIT, NORMAL}) begin
			unique case (addr)
				`ADDR_WD: begin
					wd_cfg_nxt = data;
					lw_active_nxt = 1'b0;
				end
				`ADDR_CFG: begin
					second_regulator_nxt = data[`CFG_SECOND_REGULATOR_BIT];
					third_regulator_nxt = data[`CFG_THIRD_REGULATOR_BIT];
					fo_test_nxt = data[`CFG_FO_TEST_BIT];
					cyc_nxt = data[`CFG_CYC_WAKE_BIT];
					meas_nxt = data[`CFG_MEAS_BIT];
				end
				`ADDR_CAN: can_nxt = data[1:0];
				`ADDR_HS: hs_nxt = data[3:0];
				`ADDR_WKEN: wk_en_nxt = data[3:0];
				default: ;
			endcase
		end

		if (lw_expired && lw_active_r) begin
			wd_fail_nxt = 1'b1;
			go_restart = 1'b1;
		end
		if (uv_s && mode_r inside {NORMAL, STOP}) go_restart = 1'b1;

		if (go_restart) begin
			mode_nxt = RESTART;
			mode_bits_nxt = `REQ_NORMAL;
			ro_nxt = 1'b0;
			lw_active_nxt = 1'b0;
			main_on_nxt = 1'b1;
			wd_on_nxt = 1'b1;
			second_regulator_nxt = 1'b0;
			hs_nxt = 4'h0;
			if (can_mode_r != `CAN_OFF) can_nxt = `CAN_WAKE;
			if (mode_r != SLEEP && !sleep_wake) dev_nxt = `DEV_RESTART;
		end
		if (uv_s) ro_nxt = 1'b0;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mode_r <= INIT;
			mode_bits_r <= `REQ_NORMAL;
			reset_output_r <= 1'b0;
			interrupt_r <= 1'b0;
			main_regulator_r <= 1'b1;
			second_regulator_r <= 1'b0;
			third_regulator_r <= 1'b0;
			can_mode_r <= `CAN_OFF;
			high_side_outputs_r <= 4'h0;
			fail_outputs_r <= 1'b0;
			cyclic_wake_r <= 1'b0;
			watchdog_on_r <= 1'b1;
			watchdog_cfg_r <= 8'h00;
			device_status_field_r <= `DEV_NONE;
			main_supply_undervoltage_flag_r <= 1'b0;
			spi_error_flag_r <= 1'b0;
			watchdog_fail_r <= 1'b0;
			fo_test_r <= 1'b0;
			meas_r <= 1'b0;
			wk_en_r <= 4'hf;
			lw_active_r <= 1'b0;
			powerup_r <= 1'b1;
		end else begin
			mode_r <= mode_nxt;
			mode_bits_r <= mode_bits_nxt;
			reset_output_r <= ro_nxt;
			interrupt_r <= irq_nxt;
			main_regulator_r <= main_on_nxt;
			second_regulator_r <= second_regulator_nxt;
			third_regulator_r <= third_regulator_nxt;
			can_mode_r <= can_nxt;
			high_side_outputs_r <= hs_nxt;
			fail_outputs_r <= fail_nxt;
			cyclic_wake_r <= cyc_nxt;
			watchdog_on_r <= wd_on_nxt;
			watchdog_cfg_r <= wd_cfg_nxt;
			device_status_field_r <= dev_nxt;
			main_supply_undervoltage_flag_r <= uv_flag_nxt;
			spi_error_flag_r <= spi_err_nxt;
			watchdog_fail_r <= wd_fail_nxt;
			fo_test_r <= fo_test_nxt;
			meas_r <= meas_nxt;
			wk_en_r <= wk_en_nxt;
			lw_active_r <= lw_active_nxt;
			powerup_r <= powerup_nxt;
		end
	end

	// ****************
	// Checks
	// ****************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	init_frame_a: assert property (mode_r == INIT && frame_valid |=> mode_r == NORMAL)
		else $error("init frame did not enter normal");
	wd_take_a: assert property (lw_active_r && wr && addr == `ADDR_WD && mode_r inside {INIT, NORMAL}
		|=> watchdog_cfg_r == $past(data) && !lw_active_r)
		else $error("watchdog trigger not taken");
	lw_fail_a: assert property (lw_expired && lw_active_r |=> mode_r == RESTART && watchdog_fail_r)
		else $error("missed trigger did not restart");
	init_drop_a: assert property (mode_r == INIT |=> (flags & ~$past(flags)) == 4'h0)
		else $error("wake stored in init");
	uv_powerup_a: assert property (powerup_r && batt_low_s && !main_supply_undervoltage_flag_r
		|=> !main_supply_undervoltage_flag_r)
		else $error("undervoltage flagged during power-up");
	ro_low_a: assert property (uv_s |=> !reset_output_r)
		else $error("reset released while supply low");
	wake_irq_a: assert property (wake_event && mode_r inside {NORMAL, STOP} && !frame_valid
		&& !uv_s && !(lw_expired && lw_active_r) |=> interrupt_r && $stable(mode_r))
		else $error("wake in normal or stop mishandled");
	stop_ignore_a: assert property (mode_r == STOP && wr && addr == `ADDR_HS && !uv_s
		&& !(lw_expired && lw_active_r) |=> spi_error_flag_r && $stable(high_side_outputs_r))
		else $error("write in stop not refused");
	stop_sleep_a: assert property (mode_r == STOP && wr && addr == `ADDR_MODE && req == `REQ_SLEEP
		|=> mode_r == RESTART && spi_error_flag_r ##1 !reset_output_r)
		else $error("stop to sleep not refused");
	sleep_off_a: assert property (mode_r == SLEEP |-> !main_regulator_r && !watchdog_on_r
		&& !cyclic_wake_r && device_status_field_r == `DEV_SLEEP)
		else $error("sleep left supply or watchdog on");
	restart_bits_a: assert property (mode_r == RESTART |-> mode_bits_r == `REQ_NORMAL
		&& !reset_output_r)
		else $error("restart mode bits or reset wrong");

endmodule

// file: dv/host_model.sv
// Host model: sends complete 16-bit write frames as one-cycle strobes.
// Assumes the bench shares its clock and calls send after an edge.
`timescale 1ns/1ps
module host_model (
	// Clock
	input wire logic clock,
	// Frame
	output logic frame_valid,
	output logic [15:0] frame_data
);
	initial begin
		frame_valid = 1'b0;
		frame_data = 16'h0000;
	end

	// One whole frame per command
	task automatic send(input logic [6:0] a, input logic [7:0] d);
		@(posedge clock);
		#1;
		frame_valid = 1'b1;
		frame_data = {d, 1'b1, a};
		@(posedge clock);
		#1;
		frame_valid = 1'b0;
		// Stale data must not look valid
		frame_data = ~frame_data;
	endtask
endmodule

// file: dv/tb_sbc_mode_control.sv
// Self-checking bench of the operating-mode controller.
// Assumes package, header and host model are compiled first.
`timescale 1ns/1ps
`include "sbc_mode_regs.svh"
module tb_sbc_mode_control;
	import sbc_mode_pkg::*;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic main_below_reset = 1'b1;
	logic battery_below_short = 1'b1;
	logic [2:0] wake_inputs = 3'h0;
	logic can_wake = 1'b0;
	logic frame_valid;
	logic [15:0] frame_data;
	mode_type mode_r;
	logic [1:0] mode_bits_r, can_mode_r, device_status_field_r;
	logic reset_output_r, interrupt_r, main_regulator_r;
	logic second_regulator_r, third_regulator_r, fail_outputs_r;
	logic cyclic_wake_r, watchdog_on_r, wake_status_second_r;
	logic main_supply_undervoltage_flag_r, spi_error_flag_r, watchdog_fail_r;
	logic [3:0] high_side_outputs_r;
	logic [7:0] watchdog_cfg_r;
	logic [2:0] wake_status_first_r;
	logic [15:0] n_irq = 16'h0;
	int n_errors = 0;
	int n_checks = 0;

	// ****************
	// Design and host
	// ****************
	sbc_mode_control #(.RD_CYCLES(8), .LW_CYCLES(40)) sbc_mode_control_i (
		.clock, .rst_b, .frame_valid, .frame_data, .main_below_reset,
		.battery_below_short, .wake_inputs, .can_wake, .mode_r, .mode_bits_r,
		.reset_output_r, .interrupt_r, .main_regulator_r, .second_regulator_r,
		.third_regulator_r, .can_mode_r, .high_side_outputs_r, .fail_outputs_r,
		.cyclic_wake_r, .watchdog_on_r, .watchdog_cfg_r, .wake_status_first_r,
		.wake_status_second_r, .device_status_field_r,
		.main_supply_undervoltage_flag_r, .spi_error_flag_r, .watchdog_fail_r
	);
	host_model host_i (.clock, .frame_valid, .frame_data);

	always #5 clock = ~clock;
	always @(posedge clock) if (interrupt_r === 1'b1) n_irq++;

	// ****************
	// Tasks
	// ****************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic cmd(input logic [6:0] a, input logic [7:0] d);
		host_i.send(a, d);
		tick(2);
	endtask

	task automatic final_report();
		if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic wait_mode(input mode_type m);
		for (int i = 0; i < 200 && mode_r !== m; i++) tick(1);
		if (mode_r !== m) begin
			n_errors++;
			$display("wrong value at %0t: mode wait timed out", $time);
			final_report();
		end
	endtask

	task automatic restart_back();
		wait_mode(NORMAL);
		chk(reset_output_r, 1'b1);
		cmd(`ADDR_WD, 8'h5a);
	endtask

	task automatic wake(input int p);
		if (p == 3) can_wake = 1'b1;
		else wake_inputs[p] = 1'b1;
		tick(4);
		can_wake = 1'b0;
		wake_inputs = 3'h0;
		tick(3);
	endtask

	// ****************
	// Sequence
	// ****************
	initial begin
		tick(4);
		rst_b = 1'b1;
		tick(20);
		chk(reset_output_r, 1'b0);
		chk({main_supply_undervoltage_flag_r, fail_outputs_r}, 2'h0);
		main_below_reset = 1'b0;
		battery_below_short = 1'b0;
		wake(0);
		chk(n_irq, 16'h0);
		chk(wake_status_first_r, 3'h0);
		tick(14);
		chk(reset_output_r, 1'b1);
		chk(mode_r, INIT);
		cmd(`ADDR_WD, 8'h5a);
		chk(mode_r, NORMAL);
		chk(watchdog_cfg_r, 8'h5a);
		chk({second_regulator_r, third_regulator_r, can_mode_r}, 4'h0);
		chk({high_side_outputs_r, fail_outputs_r}, 5'h0);
		cmd(`ADDR_CFG, 8'h04);
		chk(fail_outputs_r, 1'b1);
		cmd(`ADDR_CFG, 8'h0b);
		chk(fail_outputs_r, 1'b0);
		cmd(`ADDR_CAN, {6'h0, `CAN_ACTIVE});
		cmd(`ADDR_HS, 8'h05);
		wake(0);
		chk(n_irq, 16'h1);
		chk(mode_r, NORMAL);
		chk(wake_status_first_r, 3'h1);
		host_i.send(`ADDR_MODE, {6'h0, `REQ_STOP});
		tick(1);
		chk(mode_r, STOP);
		chk(mode_bits_r, `REQ_STOP);
		tick(1);
		chk(n_irq, 16'h2);
		cmd(`ADDR_HS, 8'h00);
		chk(high_side_outputs_r, 4'h5);
		chk(spi_error_flag_r, 1'b1);
		cmd(`ADDR_CLR, 8'h41);
		chk({spi_error_flag_r, wake_status_first_r}, 4'h0);
		cmd(`ADDR_WD, 8'h33);
		chk(spi_error_flag_r, 1'b0);
		chk(watchdog_cfg_r, 8'h5a);
		chk({second_regulator_r, third_regulator_r, can_mode_r, cyclic_wake_r}, 5'h1f);
		wake(2);
		chk(n_irq, 16'h3);
		chk(mode_r, STOP);
		host_i.send(`ADDR_MODE, {6'h0, `REQ_SLEEP});
		tick(3);
		chk({mode_r, spi_error_flag_r}, {RESTART, 1'b1});
		chk(reset_output_r, 1'b0);
		chk(mode_bits_r, 2'h0);
		restart_back();
		chk({second_regulator_r, high_side_outputs_r, third_regulator_r}, 6'h01);
		chk(wake_status_first_r, 3'h4);
		host_i.send(`ADDR_MODE, {6'h0, `REQ_SLEEP});
		tick(3);
		chk(mode_r, RESTART);
		restart_back();
		cmd(`ADDR_CLR, 8'hcf);
		for (int k = 0; k < 2; k++) begin
			cmd(`ADDR_WKEN, k ? 8'h03 : 8'h00);
			cmd(`ADDR_CFG, k ? 8'h1b : 8'h0b);
			host_i.send(`ADDR_MODE, {6'h0, `REQ_SLEEP});
			tick(3);
			chk({mode_r, spi_error_flag_r}, {RESTART, 1'b1});
			chk(device_status_field_r, `DEV_RESTART);
			restart_back();
			cmd(`ADDR_CLR, 8'h40);
		end
		cmd(`ADDR_WKEN, 8'h0f);
		cmd(`ADDR_CFG, 8'h0b);
		cmd(`ADDR_CAN, {6'h0, `CAN_ACTIVE});
		cmd(`ADDR_MODE, {6'h0, `REQ_SLEEP});
		chk(mode_r, SLEEP);
		chk({main_regulator_r, watchdog_on_r, cyclic_wake_r}, 3'h0);
		chk({second_regulator_r, third_regulator_r}, 2'h3);
		chk(can_mode_r, `CAN_WAKE);
		chk(device_status_field_r, `DEV_SLEEP);
		main_below_reset = 1'b1;
		wake(3);
		chk(mode_r, RESTART);
		chk(wake_status_second_r, 1'b1);
		chk(reset_output_r, 1'b0);
		chk(main_supply_undervoltage_flag_r, 1'b1);
		main_below_reset = 1'b0;
		restart_back();
		chk(device_status_field_r, `DEV_SLEEP);
		host_i.send(`ADDR_MODE, {6'h0, `REQ_STOP});
		tick(3);
		chk(mode_r, STOP);
		// Soft reset is exempt in stop; no trigger afterwards
		cmd(`ADDR_MODE, {6'h0, `REQ_SOFT_RESET});
		chk({mode_r, device_status_field_r, spi_error_flag_r}, {RESTART, `DEV_RESTART, 1'b0});
		chk(watchdog_fail_r, 1'b0);
		wait_mode(NORMAL);
		wait_mode(RESTART);
		chk(watchdog_fail_r, 1'b1);
		final_report();
	end
endmodule
